// [verilog/shift_unit_pkg.sv]
// shared constants, types and register map of the shift, rotate and
// sign/test execution unit.
// assumes one 25 MHz clock and a 32-bit AHB-Lite register bus.
package shift_unit_pkg;

  localparam int AC_W   = 38;  // S, Q, P and bits 1..35
  localparam int MQ_W   = 36;  // S and bits 1..35
  localparam int ADDR_W = 15;  // address field, bits 21..35
  localparam int CNT_W  = 8;   // effective address bits 28..35
  localparam int TAG_W  = 3;

  // bit positions inside the packed accumulator and mq vectors
  localparam int AC_S  = 37;
  localparam int AC_Q  = 36;
  localparam int AC_P  = 35;
  localparam int AC_B1 = 34;
  localparam int MQ_S  = 35;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_INDEX  = 8'h08;
  localparam logic [7:0] OFF_AC_LO  = 8'h0c;
  localparam logic [7:0] OFF_AC_HI  = 8'h10;
  localparam logic [7:0] OFF_MQ_LO  = 8'h14;
  localparam logic [7:0] OFF_MQ_HI  = 8'h18;
  localparam logic [7:0] OFF_IC     = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // field positions
  localparam int CMD_SS_LSB   = 3;   // storage-sign variant, cmd bits 4:3
  localparam int ADDR_TAG_LSB = 15;  // tag, addr bits 17:15
  localparam int ST_BUSY = 0;
  localparam int ST_OVF  = 1;
  localparam int ST_DIV  = 2;
  localparam int ST_IOC  = 3;
  localparam int ST_SKIP = 4;

  // reset values
  localparam logic [AC_W-1:0]   AC_RST = 38'h00_0000_0000;
  localparam logic [MQ_W-1:0]   MQ_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] IC_RST = 15'h0000;

  // sub-operation codes carried in the low address bits
  localparam logic [3:0] SUB_CHS = 4'h0;  // change sign
  localparam logic [3:0] SUB_SSP = 4'h1;  // set sign plus
  localparam logic [3:0] SUB_LBT = 4'h2;  // low-order bit test
  localparam logic [3:0] SUB_PBT = 4'h3;  // p bit test
  localparam logic [3:0] SUB_DCT = 4'h4;  // divide check test
  localparam logic [3:0] SUB_ICT = 4'h5;  // i-o check test
  localparam int SUB_SW_BIT = 3;          // set: sense switch test

  typedef enum logic [2:0] {
    OP_LSHL  = 3'h0, OP_LSHR = 3'h1, OP_LONGL = 3'h2, OP_LONGR = 3'h3,
    OP_ROT   = 3'h4, OP_SIGNT = 3'h5, OP_STSIGN = 3'h6, OP_NONE = 3'h7
  } op_t;

  typedef enum logic [1:0] {
    SS_MINUS = 2'h0, SS_PLUS = 2'h1, SS_TMINUS = 2'h2, SS_TPLUS = 2'h3
  } ss_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_DECODE = 3'h1, S_SHIFT = 3'h2, S_FINISH = 3'h3,
    S_MEM_RD = 3'h4, S_MEM_WR = 3'h5, S_STEP = 3'h6
  } state_t;

  typedef struct packed {
    logic              valid;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [MQ_W-1:0]   wdata;
  } mem_req_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] off;
  } ahb_addr_t;

endpackage

// [verilog/shift_counter.sv]
// down-counter that paces shifts and rotates one position per step.
// assumes load and dec are never raised together.
`timescale 1ns/10ps
module shift_counter #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  output logic      [W-1:0] count,
  output logic              zero
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // a load wins; decrement only while nonzero so it never wraps
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (dec && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count = cnt_ff;
  assign zero  = (cnt_ff == '0);
endmodule

// [verilog/eff_addr_unit.sv]
// effective address former: indexes the address field when tagged.
// assumes the index value is already selected by the tag elsewhere.
`timescale 1ns/10ps
module eff_addr_unit #(
  parameter int AW = 15,
  parameter int TW = 3
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          calc,
  input  wire logic [AW-1:0] base,
  input  wire logic [TW-1:0] tag,
  input  wire logic [AW-1:0] index,
  output logic      [AW-1:0] ea
);
  logic [AW-1:0] ea_ff;
  logic [AW-1:0] nxt_ea;

  // address arithmetic wraps modulo the field width, like the adder
  always_comb begin
    nxt_ea = ea_ff;
    if (calc) begin
      nxt_ea = (tag != '0) ? AW'(base + index) : base;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_ff <= '0;
    end else begin
      ea_ff <= nxt_ea;
    end
  end

  assign ea = ea_ff;
endmodule

// [verilog/shift_rotate_sign_test_unit.sv]
// shift, rotate, sign alteration, skip test and storage-sign unit.
// assumes a single-slave AHB-Lite bus, a core storage port that
// answers each held request with a one-cycle mem_ack, and console
// switches arriving asynchronously on pins.
//
// Overview of operation
// - effective address is address field plus index when tag nonzero
// - counter loads effective address bits 28..35; shifts never use storage
// - shift one place and decrement while counter nonzero; zero shifts nothing
// - logical left chains ac q..35 with mq s..35, mq 35 gets 0
// - logical shifts keep the accumulator sign unchanged
// - left shifts set overflow when a 1 leaves ac bit 1
// - logical right moves ac 35 to mq s, q gets 0, no overflow
// - long left skips mq sign; mq bit 1 enters ac 35
// - long left ends by copying mq sign into ac sign
// - long right feeds mq bit 1, ends copying ac sign to mq
// - rotate turns mq left, sign wrapping into bit 35
// - change sign inverts ac sign; set plus clears it
// - low address bits after indexing choose the sign or test operation
// - low-order test skips when ac bit 35 is one
// - p bit test skips when ac p bit is one
// - divide check test clears indicator if on, else skips
// - i-o check test behaves alike with the i-o indicator
// - sense switch test skips when the chosen switch is on
// - make minus reads word, sets sign, writes back same address
// - make plus reads word, clears sign, writes back same address
// - storage minus test skips when the read sign is one
// - storage plus test skips on sign zero; accumulator never touched
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module shift_rotate_sign_test_unit
  import shift_unit_pkg::*;
#(
  parameter int SWITCHES = 6
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  output mem_req_t               mem_req,
  input  wire logic              mem_ack,
  input  wire logic [MQ_W-1:0]   mem_rdata,
  input  wire logic [SWITCHES-1:0] sense_sw,
  input  wire logic              div_check_set,
  input  wire logic              io_check_set
);
  // elaboration stops on a switch count the select logic cannot index
  if (SWITCHES < 1 || SWITCHES > 8) begin : g_bad_switches
    $error("SWITCHES must lie in 1..8");
  end

  state_t            state_ff, nxt_state;
  logic [AC_W-1:0]   ac_ff, nxt_ac;
  logic [MQ_W-1:0]   mq_ff, nxt_mq;
  logic [ADDR_W-1:0] ic_ff, nxt_ic;
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic [ADDR_W-1:0] index_ff, nxt_index;
  logic [TAG_W-1:0]  tag_ff, nxt_tag;
  logic [4:0]        cmd_ff, nxt_cmd;
  logic [MQ_W-1:0]   mdb_ff, nxt_mdb;
  mem_req_t          mreq_ff, nxt_mreq;
  logic              skip_ff, nxt_skip;
  logic              ovf_ff, nxt_ovf;
  logic              div_ff, nxt_div;
  logic              ioc_ff, nxt_ioc;
  ahb_addr_t         ap_ff, nxt_ap;
  logic              ap_vld_ff, nxt_ap_vld;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [SWITCHES-1:0] sw_meta_ff, sw_sync_ff;

  logic              ea_calc, cnt_load, cnt_dec, cnt_zero;
  logic              ovf_set, ovf_clr, div_clr, ioc_clr;
  logic              bus_wr, idle;
  logic [ADDR_W-1:0] ea;
  logic [CNT_W-1:0]  cnt;
  logic [31:0]       status;
  op_t               op;
  ss_t               ss;

  assign op     = op_t'(cmd_ff[2:0]);
  assign ss     = ss_t'(cmd_ff[CMD_SS_LSB +: 2]);
  assign idle   = (state_ff == S_IDLE);
  assign bus_wr = ap_vld_ff && ap_ff.wr;
  assign status = {27'h000_0000, skip_ff, ioc_ff, div_ff, ovf_ff, !idle};

  eff_addr_unit #(.AW(ADDR_W), .TW(TAG_W)) u_ea (
    .hclk    (hclk),
    .hresetn (hresetn),
    .calc    (ea_calc),
    .base    (base_ff),
    .tag     (tag_ff),
    .index   (index_ff),
    .ea      (ea)
  );

  shift_counter #(.W(CNT_W)) u_cnt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (cnt_load),
    .load_val (ea[CNT_W-1:0]),
    .dec      (cnt_dec),
    .count    (cnt),
    .zero     (cnt_zero)
  );

  // bus slave: zero wait states, read data registered in address phase;
  // a read right behind a write to the same register sees the old value
  always_comb begin
    nxt_ap_vld = hsel && hready && htrans[1];
    nxt_ap     = ap_ff;
    nxt_rdata  = rdata_ff;
    if (hsel && hready && htrans[1]) begin
      nxt_ap.wr  = hwrite;
      nxt_ap.off = haddr[7:0];
      if (!hwrite) begin
        unique case (haddr[7:0])
          OFF_CMD:    nxt_rdata = {27'h000_0000, cmd_ff};
          OFF_ADDR:   nxt_rdata = {14'h0000, tag_ff, base_ff};
          OFF_INDEX:  nxt_rdata = {17'h0_0000, index_ff};
          OFF_AC_LO:  nxt_rdata = ac_ff[31:0];
          OFF_AC_HI:  nxt_rdata = {26'h000_0000, ac_ff[AC_W-1:32]};
          OFF_MQ_LO:  nxt_rdata = mq_ff[31:0];
          OFF_MQ_HI:  nxt_rdata = {28'h000_0000, mq_ff[MQ_W-1:32]};
          OFF_IC:     nxt_rdata = {17'h0_0000, ic_ff};
          OFF_STATUS: nxt_rdata = status;
          default:    nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_vld_ff <= 1'b0;
      ap_ff     <= '0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      ap_vld_ff <= nxt_ap_vld;
      ap_ff     <= nxt_ap;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // console switches are asynchronous: two flops before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_meta_ff <= '0;
      sw_sync_ff <= '0;
    end else begin
      sw_meta_ff <= sense_sw;
      sw_sync_ff <= sw_meta_ff;
    end
  end

  // indicators: a set in the same cycle as a clear wins
  always_comb begin
    ovf_clr = bus_wr && ap_ff.off == OFF_STATUS && hwdata[ST_OVF];
    nxt_ovf = ovf_set || (ovf_ff && !ovf_clr);
    nxt_div = div_check_set || (div_ff && !div_clr);
    nxt_ioc = io_check_set || (ioc_ff && !ioc_clr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_ff <= 1'b0;
      div_ff <= 1'b0;
      ioc_ff <= 1'b0;
    end else begin
      ovf_ff <= nxt_ovf;
      div_ff <= nxt_div;
      ioc_ff <= nxt_ioc;
    end
  end

  // sequencer and datapath
  always_comb begin
    nxt_state = state_ff;
    nxt_ac    = ac_ff;
    nxt_mq    = mq_ff;
    nxt_ic    = ic_ff;
    nxt_base  = base_ff;
    nxt_index = index_ff;
    nxt_tag   = tag_ff;
    nxt_cmd   = cmd_ff;
    nxt_mdb   = mdb_ff;
    nxt_mreq  = mreq_ff;
    nxt_skip  = skip_ff;
    ea_calc   = 1'b0;
    cnt_load  = 1'b0;
    cnt_dec   = 1'b0;
    ovf_set   = 1'b0;
    div_clr   = 1'b0;
    ioc_clr   = 1'b0;
    // software may only alter operands while no instruction runs
    if (bus_wr && idle) begin
      unique case (ap_ff.off)
        OFF_CMD: begin
          nxt_cmd   = hwdata[4:0];
          nxt_skip  = 1'b0;
          ea_calc   = 1'b1;
          nxt_state = S_DECODE;
        end
        OFF_ADDR: begin
          nxt_base = hwdata[ADDR_W-1:0];
          nxt_tag  = hwdata[ADDR_TAG_LSB +: TAG_W];
        end
        OFF_INDEX: nxt_index = hwdata[ADDR_W-1:0];
        OFF_AC_LO: nxt_ac[31:0] = hwdata;
        OFF_AC_HI: nxt_ac[AC_W-1:32] = hwdata[AC_W-33:0];
        OFF_MQ_LO: nxt_mq[31:0] = hwdata;
        OFF_MQ_HI: nxt_mq[MQ_W-1:32] = hwdata[MQ_W-33:0];
        OFF_IC:    nxt_ic = hwdata[ADDR_W-1:0];
        default: ;
      endcase
    end
    unique case (state_ff)
      S_IDLE: ;
      S_DECODE: begin
        unique case (op)
          OP_LSHL, OP_LSHR, OP_LONGL, OP_LONGR, OP_ROT: begin
            cnt_load  = 1'b1;
            nxt_state = S_SHIFT;
          end
          OP_SIGNT: begin
            nxt_state = S_STEP;
            if (ea[SUB_SW_BIT]) begin
              // switch numbers beyond the fitted set never skip
              nxt_skip = (32'(ea[2:0]) < SWITCHES) &&
                         sw_sync_ff[ea[2:0]];
            end else begin
              unique case (ea[3:0])
                SUB_CHS: nxt_ac[AC_S] = !ac_ff[AC_S];
                SUB_SSP: nxt_ac[AC_S] = 1'b0;
                SUB_LBT: nxt_skip = ac_ff[0];
                SUB_PBT: nxt_skip = ac_ff[AC_P];
                SUB_DCT: begin
                  nxt_skip = !div_ff;
                  div_clr  = div_ff;
                end
                SUB_ICT: begin
                  nxt_skip = !ioc_ff;
                  ioc_clr  = ioc_ff;
                end
                default: ;
              endcase
            end
          end
          OP_STSIGN: begin
            nxt_mreq  = '{valid: 1'b1, we: 1'b0, addr: ea, wdata: '0};
            nxt_state = S_MEM_RD;
          end
          OP_NONE: nxt_state = S_STEP;
        endcase
      end
      S_SHIFT: begin
        if (cnt_zero) begin
          nxt_state = S_FINISH;
        end else begin
          cnt_dec = 1'b1;
          unique case (op)
            OP_LSHL: begin
              {nxt_ac[AC_Q:0], nxt_mq} = {ac_ff[AC_P:0], mq_ff, 1'b0};
              ovf_set = ac_ff[AC_B1];
            end
            OP_LSHR: {nxt_ac[AC_Q:0], nxt_mq} =
              {1'b0, ac_ff[AC_Q:0], mq_ff[MQ_S:1]};
            OP_LONGL: begin
              {nxt_ac[AC_Q:0], nxt_mq[MQ_S-1:0]} =
                {ac_ff[AC_P:0], mq_ff[MQ_S-1:0], 1'b0};
              ovf_set = ac_ff[AC_B1];
            end
            OP_LONGR: {nxt_ac[AC_Q:0], nxt_mq[MQ_S-1:0]} =
              {1'b0, ac_ff[AC_Q:0], mq_ff[MQ_S-1:1]};
            OP_ROT: nxt_mq = {mq_ff[MQ_S-1:0], mq_ff[MQ_S]};
            default: ;
          endcase
        end
      end
      S_FINISH: begin
        if (op == OP_LONGL) begin
          nxt_ac[AC_S] = mq_ff[MQ_S];
        end
        if (op == OP_LONGR) begin
          nxt_mq[MQ_S] = ac_ff[AC_S];
        end
        nxt_state = S_STEP;
      end
      S_MEM_RD: begin
        if (mem_ack) begin
          nxt_mdb = mem_rdata;
          unique case (ss)
            SS_MINUS, SS_PLUS: begin
              nxt_mdb[MQ_S] = (ss == SS_MINUS);
              nxt_mreq.we    = 1'b1;
              nxt_mreq.wdata = nxt_mdb; // the buffer goes back whole
              nxt_state      = S_MEM_WR;
            end
            SS_TMINUS: begin
              nxt_skip       = mem_rdata[MQ_S];
              nxt_mreq.valid = 1'b0;
              nxt_state      = S_STEP;
            end
            SS_TPLUS: begin
              nxt_skip       = !mem_rdata[MQ_S];
              nxt_mreq.valid = 1'b0;
              nxt_state      = S_STEP;
            end
          endcase
        end
      end
      S_MEM_WR: begin
        if (mem_ack) begin
          nxt_mreq.valid = 1'b0;
          nxt_state      = S_STEP;
        end
      end
      S_STEP: begin
        nxt_ic    = ic_ff + ADDR_W'(1) + ADDR_W'(skip_ff);
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE; // unused code falls back to idle
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= S_IDLE;
      ac_ff    <= AC_RST;
      mq_ff    <= MQ_RST;
      ic_ff    <= IC_RST;
      base_ff  <= '0;
      index_ff <= '0;
      tag_ff   <= '0;
      cmd_ff   <= '0;
      mdb_ff   <= '0;
      mreq_ff  <= '0;
      skip_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ac_ff    <= nxt_ac;
      mq_ff    <= nxt_mq;
      ic_ff    <= nxt_ic;
      base_ff  <= nxt_base;
      index_ff <= nxt_index;
      tag_ff   <= nxt_tag;
      cmd_ff   <= nxt_cmd;
      mdb_ff   <= nxt_mdb;
      mreq_ff  <= nxt_mreq;
      skip_ff  <= nxt_skip;
    end
  end

  assign mem_req = mreq_ff;

  // checks on the sequencer and datapath
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic shifting;
  assign shifting = (state_ff == S_SHIFT) && !cnt_zero;

  sequence rd_done_s;
    state_ff == S_MEM_RD && mem_ack;
  endsequence

  sequence wr_issued_s;
    mem_req.valid && mem_req.we && mem_req.addr == $past(ea);
  endsequence

  a_count_load: assert property (
    state_ff == S_DECODE && op < OP_SIGNT
    |=> cnt == $past(ea[CNT_W-1:0])) else $error("count not loaded");
  a_count_step: assert property (shifting
    |=> cnt == $past(cnt) - 8'h01) else $error("count not decremented");
  a_zero_stops: assert property (state_ff == S_SHIFT && cnt_zero
    |=> state_ff == S_FINISH && $stable(mq_ff)) else $error("shift at zero");
  a_lshl_chain: assert property (shifting && op == OP_LSHL
    |=> ac_ff[0] == $past(mq_ff[MQ_S]) && !mq_ff[0] &&
        $stable(ac_ff[AC_S])) else $error("logical left wrong");
  a_lshr_chain: assert property (shifting && op == OP_LSHR
    |=> mq_ff[MQ_S] == $past(ac_ff[0]) && !ac_ff[AC_Q] &&
        $stable(ac_ff[AC_S])) else $error("logical right wrong");
  a_ovf_left: assert property (shifting && ac_ff[AC_B1]
    && op inside {OP_LSHL, OP_LONGL} |=> ovf_ff)
    else $error("overflow missed");
  a_long_sign: assert property (
    state_ff == S_FINISH && op == OP_LONGL
    |=> ac_ff[AC_S] == $past(mq_ff[MQ_S])) else $error("sign not copied");
  a_rotate_wrap: assert property (shifting && op == OP_ROT
    |=> mq_ff == {$past(mq_ff[MQ_S-1:0]), $past(mq_ff[MQ_S])}
        && $stable(ac_ff)) else $error("rotate wrong");
  a_make_minus: assert property (rd_done_s
    ##0 (ss == SS_MINUS && op == OP_STSIGN)
    |=> wr_issued_s ##0 mem_req.wdata[MQ_S])
    else $error("minus write-back wrong");
  a_make_plus: assert property (rd_done_s
    ##0 (ss == SS_PLUS && op == OP_STSIGN)
    |=> wr_issued_s ##0 !mem_req.wdata[MQ_S])
    else $error("plus write-back wrong");
  a_sreg_wback: assert property (mem_req.valid && mem_req.we
    |-> mem_req.wdata == mdb_ff) else $error("write-back not from buffer");
  a_ac_untouched: assert property (
    state_ff inside {S_MEM_RD, S_MEM_WR}
    |=> $stable(ac_ff)) else $error("accumulator disturbed");
  a_ic_skip: assert property (state_ff == S_STEP
    |=> ic_ff == $past(ic_ff) + 15'h0001 + 15'($past(skip_ff)))
    else $error("counter step wrong");
endmodule

// [tb/core_store_model.sv]
// storage partner: answers each held request after lat extra cycles.
// assumes the unit holds a request until it has seen the one-cycle ack.
`timescale 1ns/10ps
module core_store_model
  import shift_unit_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire mem_req_t        req,
  input  wire logic [1:0]      lat,
  output logic                 ack,
  output logic      [MQ_W-1:0] rdata
);
  logic [MQ_W-1:0] mem [0:15];
  logic [1:0]      wait_ff;

  // idle data lines toggle so a stale word never passes for a read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack     <= 1'h0;
      wait_ff <= 2'h0;
      rdata   <= '0;
    end else begin
      ack   <= 1'h0;
      rdata <= ~rdata;
      if (req.valid && !ack) begin
        if (wait_ff == lat) begin
          wait_ff <= 2'h0;
          ack     <= 1'h1;
          if (req.we)
            mem[req.addr[3:0]] <= req.wdata;
          else
            rdata <= mem[req.addr[3:0]];
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end
    end
  end
endmodule

// [tb/tb.sv]
// bench: drives the unit over ahb-lite and checks it against a model.
// assumes the package and the storage partner model compile first.
`timescale 1ns/10ps
module tb
  import shift_unit_pkg::*;
;
  logic            hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, dph = 0;
  logic            hready, hreadyout, hresp, mem_ack, dset = 0, iset = 0;
  logic [31:0]     haddr = '0, hwdata = '0, hrdata;
  logic [1:0]      htrans = '0, lat = '0;
  logic [2:0]      hsize = 3'h2;
  logic [5:0]      sw = '0;
  logic [MQ_W-1:0] mem_rdata, mq_e;
  logic [AC_W-1:0] ac_e;
  logic [14:0]     ic_e = '0;
  logic            ovf_e, div_e = 0, ioc_e = 0, skip_e;
  mem_req_t        mem_req;
  logic [35:0]     exp_q[$];
  string           nm_q[$];
  int              error_cnt = 0, checks = 0, seed = 86214, memv = 0;

  assign hready = hreadyout;
  // 25 mhz bus clock
  always #20 hclk = ~hclk;

  shift_rotate_sign_test_unit #(.SWITCHES(6)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .sense_sw(sw), .div_check_set(dset),
    .io_check_set(iset));
  core_store_model pm (.hclk(hclk), .hresetn(hresetn), .req(mem_req),
    .lat(lat), .ack(mem_ack), .rdata(mem_rdata));

  task automatic chk(input string n, input logic [35:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic note(input string n, input logic [35:0] e);
    exp_q.push_back(e);
    nm_q.push_back(n);
  endtask

  // bounded wait for hready; running out ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'h1 && k < 64);
    if (k >= 64) begin
      error_cnt++;
      conclude();
    end
  endtask

  // one single word transfer; c marks a read result for the monitor
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic c,
                      output logic [31:0] v);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    dph    <= c;
    wait_rdy();
    v = hrdata;
    dph <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'h1, a, d, 1'h0, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] v;
    note(n, {4'h0, e});
    xfer(1'h0, a, 32'h0, 1'h1, v);
  endtask

  function automatic logic [63:0] rnd64();
    return {$random(seed), $random(seed)};
  endfunction

  // takes the oldest note whenever a marked read or a storage write shows up
  always @(posedge hclk) begin
    if (mem_req.valid === 1'h1)
      memv++;
    if (dph === 1'h1)
      chk("hresp", {35'h0, hresp}, 36'h0);
    if (dph === 1'h1 || (mem_req.valid & mem_req.we & mem_ack) === 1'h1)
      chk(nm_q.pop_front(), dph ? {4'h0, hrdata} : mem_req.wdata,
          exp_q.pop_front());
  end

  // loads operands, indexes the count in when tagged, runs to idle
  task automatic run(input logic [4:0] cmd, input logic [7:0] low);
    logic [31:0] v;
    logic [14:0] ix, e;
    logic [2:0]  t;
    int          k;
    ix = 15'($random(seed));
    t = 3'($random(seed));
    e = {7'($random(seed)), low};
    lat <= 2'($random(seed));
    wr(OFF_AC_LO, ac_e[31:0]);
    wr(OFF_AC_HI, {26'h0, ac_e[37:32]});
    wr(OFF_MQ_LO, mq_e[31:0]);
    wr(OFF_MQ_HI, {28'h0, mq_e[35:32]});
    wr(OFF_INDEX, {17'h0, ix});
    wr(OFF_ADDR, {14'h0, t, e - (t != 3'h0 ? ix : 15'h0)});
    wr(OFF_STATUS, 32'h2);
    memv = 0;
    wr(OFF_CMD, {27'h0, cmd});
    k = 0;
    do begin
      xfer(1'h0, OFF_STATUS, 32'h0, 1'h0, v);
      k++;
    end while (v[ST_BUSY] !== 1'h0 && k < 400);
    if (k >= 400) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic verify();
    rd(OFF_AC_LO, ac_e[31:0], "ac_lo");
    rd(OFF_AC_HI, {26'h0, ac_e[37:32]}, "ac_hi");
    rd(OFF_MQ_LO, mq_e[31:0], "mq_lo");
    rd(OFF_MQ_HI, {28'h0, mq_e[35:32]}, "mq_hi");
    rd(OFF_IC, {17'h0, ic_e}, "ic");
    rd(OFF_STATUS, {27'h0, skip_e, ioc_e, div_e, ovf_e, 1'h0}, "status");
  endtask

  // reference shift of n places, one place per counter step
  task automatic predict(input logic [2:0] op, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      b = ac_e[0];
      case (op)
        OP_LSHL: begin
          b = mq_e[35];
          mq_e = {mq_e[34:0], 1'h0};
        end
        OP_LONGL: begin
          b = mq_e[34];
          mq_e[34:0] = {mq_e[33:0], 1'h0};
        end
        OP_LSHR: mq_e = {b, mq_e[35:1]};
        OP_LONGR: mq_e[34:0] = {b, mq_e[34:1]};
        default: mq_e = {mq_e[34:0], mq_e[35]};
      endcase
      if (op == OP_LSHL || op == OP_LONGL) begin
        ovf_e |= ac_e[AC_B1];
        ac_e[36:0] = {ac_e[35:0], b};
      end else if (op != OP_ROT)
        ac_e[36:0] = {1'h0, ac_e[36:1]};
    end
    if (op == OP_LONGL)
      ac_e[AC_S] = mq_e[MQ_S];
    if (op == OP_LONGR)
      mq_e[MQ_S] = ac_e[AC_S];
  endtask

  initial begin
    logic [7:0] cnt [4];
    cnt = '{8'h00, 8'h01, 8'h25, 8'hff};
    ovf_e = 1'h0;
    skip_e = 1'h0;
    ac_e = AC_RST;
    mq_e = MQ_RST;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    verify();
    rd(8'h24, 32'h0, "unmapped");
    $display("test reset values done");
    // every shift kind and rotate at boundary counts
    for (int op = 0; op < 5; op++)
      for (int c = 0; c < 4; c++) begin
        ac_e = 38'(rnd64());
        mq_e = 36'(rnd64());
        run({2'h0, 3'(op)}, cnt[c]);
        ovf_e = 1'h0;
        predict(3'(op), cnt[c]);
        ic_e += 15'h1;
        verify();
        chk("storage_use", 36'(memv), 36'h0);
      end
    // the no-operation code only steps the instruction counter
    run(5'h07, 8'h00);
    ic_e += 15'h1;
    verify();
    $display("test shifts and rotate done");
    // sign and test sub-codes, indicators set then left clear
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 16; s++) begin
        ac_e = 38'(rnd64());
        sw <= 6'($random(seed));
        dset <= p == 0;
        iset <= p == 0;
        @(posedge hclk);
        dset <= 1'h0;
        iset <= 1'h0;
        div_e |= p == 0;
        ioc_e |= p == 0;
        run({2'h0, OP_SIGNT}, 8'(s));
        skip_e = 1'h0;
        case (s)
          0: ac_e[AC_S] = ~ac_e[AC_S];
          1: ac_e[AC_S] = 1'h0;
          2: skip_e = ac_e[0];
          3: skip_e = ac_e[AC_P];
          4: begin
            skip_e = ~div_e;
            div_e = 1'h0;
          end
          5: begin
            skip_e = ~ioc_e;
            ioc_e = 1'h0;
          end
          6, 7: skip_e = 1'h0;
          default: skip_e = s < 14 ? sw[s - 8] : 1'h0;
        endcase
        ic_e += 15'(1 + skip_e);
        verify();
      end
    $display("test sign and skip tests done");
    // storage sign variants, each sign value seen once per variant
    for (int i = 0; i < 8; i++) begin
      logic [35:0] w;
      w = 36'(rnd64());
      w[35] = i[2];
      pm.mem[i] = w;
      ac_e = 38'(rnd64());
      if (i[1] == 1'h0)
        note("store_word", {~i[0], w[34:0]});
      run({i[1:0], OP_STSIGN}, 8'(i));
      skip_e = i[1] & (w[35] ^ i[0]);
      ic_e += 15'(1 + skip_e);
      verify();
      chk("mem_word", pm.mem[i], {i[1] ? w[35] : ~i[0], w[34:0]});
    end
    $display("test storage sign done");
    conclude();
  end
endmodule
